// *** i2c_slave_pkg.sv ***
// Constants, types and state codes shared by the I2C slave and its time-out counter.
// Behaviour
// - Address match wakes device when wake enabled.
// - Ninth clock SDA sampled into received-ack flag.
// - Transmitter continues on ack, releases SDA otherwise.
// - SDA falling with SCL high sets busy.
// - Seven address bits MSB first, match flags.
// - Eighth bit stored as slave read/write flag.
// - Matched address acknowledged low on ninth bit.
// - Match, byte done, time-out share one interrupt.
// - SCL held low until data write or read.
// - Data bytes eight bits, MSB first, after ack.
// - Receiver drives ack-to-send bit on ninth clock.
// - Slave active only in mode 110 and enabled.
// - Slave never generates a START condition.
// - Counter starts after match, cleared on SCL fall.
// - Period expiry times out; STOP halts time-out.
// - Overflow stops counter, clears enable, sets flag, interrupts.
// - Time-out resets status flags, keeps data and address.
// - Period is (select plus one) times 32 subclocks.
// - STOP clears the bus busy flag.
// - Done flag low during byte, high at end.
package i2c_slave_pkg;

  localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int TMO_CNT_W = 12;
  localparam logic [TMO_CNT_W-1:0] TMO_UNIT_SUBCLK = 12'h020;
  localparam logic [TMO_CNT_W-1:0] TMO_ONE = 12'h001;

  // Power-on values of the status flags.
  localparam logic HCF_POR = 1'h1;
  localparam logic ADDR_MATCH_FLAG_POR = 1'h0;
  localparam logic HBB_POR = 1'h0;
  localparam logic SRW_POR = 1'h0;
  localparam logic ACK_RECEIVED_FLAG_POR = 1'h1;
  localparam logic TMO_EN_POR = 1'h0;
  localparam logic TMO_FLAG_POR = 1'h0;
  localparam logic [5:0] TMO_SEL_POR = 6'h00;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_HOLD = 7'h08,
    ST_DATA = 7'h10,
    ST_DATA_ACK = 7'h20,
    ST_WAIT_STOP = 7'h40
  } slave_state_t;

  function automatic logic [TMO_CNT_W-1:0] tmo_limit(input logic [5:0] sel);
    tmo_limit = 12'(({6'h00, sel} + TMO_ONE) * TMO_UNIT_SUBCLK);
  endfunction

endpackage

// *** tmo_link_if.sv ***
// Signals between the core-clock slave and the subclock time-out counter.
`timescale 1ns/1ps
interface tmo_link_if;
  logic run;
  logic fall_tgl;
  logic [5:0] period_sel;
  logic ovf_tgl;

  modport core (output run, output fall_tgl, output period_sel, input ovf_tgl);
  modport counter (input run, input fall_tgl, input period_sel, output ovf_tgl);
endinterface

// *** tmo_counter.sv ***
// Bus time-out counter running on the low-speed subclock.
`timescale 1ns/1ps
module tmo_counter (
  input wire logic i_sub_clk,
  input wire logic i_rst,
  tmo_link_if.counter link
);

  typedef struct packed {
    logic run_m;
    logic run_s;
    logic run_d;
    logic fall_m;
    logic fall_s;
    logic fall_d;
    logic stopped;
    logic ovf_tgl;
    logic [i2c_slave_pkg::TMO_CNT_W-1:0] cnt;
    logic [i2c_slave_pkg::TMO_CNT_W-1:0] limit;
  } cnt_state_t;

  cnt_state_t r_reg;
  cnt_state_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.run_m = link.run;
    r_next.run_s = r_reg.run_m;
    r_next.run_d = r_reg.run_s;
    r_next.fall_m = link.fall_tgl;
    r_next.fall_s = r_reg.fall_m;
    r_next.fall_d = r_reg.fall_s;
    if (!r_reg.run_s) begin
      r_next.cnt = '0;
      r_next.stopped = 1'b0;
    end else begin
      // The period select is captured once here, when the run level rises; a later write takes effect on the next run.
      if (!r_reg.run_d) begin
        r_next.limit = i2c_slave_pkg::tmo_limit(link.period_sel);
      end
      if (r_reg.fall_s ^ r_reg.fall_d) begin
        r_next.cnt = '0;
      end else if (!r_reg.stopped) begin
        r_next.cnt = r_reg.cnt + i2c_slave_pkg::TMO_ONE;
        if (r_next.cnt >= r_next.limit) begin
          r_next.ovf_tgl = ~r_reg.ovf_tgl;
          r_next.stopped = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_sub_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.ovf_tgl = r_reg.ovf_tgl;

  a_count_bound: assert property (@(posedge i_sub_clk) disable iff (i_rst)
    (r_reg.run_s && r_reg.run_d) |-> r_reg.cnt <= r_reg.limit)
    else $error("time-out count passed its limit");

  a_stop_after_ovf: assert property (@(posedge i_sub_clk) disable iff (i_rst)
    (r_reg.stopped && r_reg.run_s && !(r_reg.fall_s ^ r_reg.fall_d)) |=> $stable(r_reg.ovf_tgl))
    else $error("time-out counter did not stop after overflow");

endmodule

// *** i2c_slave_with_timeout.sv ***
// I2C slave with address match, byte transfer, SCL stretching and bus time-out.
`timescale 1ns/1ps
module i2c_slave_with_timeout (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_sub_clk,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [2:0] i_module_mode_sel,
  input wire logic i_module_enable,
  input wire logic [6:0] i_own_address,
  input wire logic i_transmit_select,
  input wire logic i_ack_to_send,
  input wire logic i_match_wake_enable,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_data_rd,
  input wire logic i_timeout_wr,
  input wire logic i_timeout_enable_wdata,
  input wire logic [5:0] i_timeout_period_wdata,
  input wire logic i_timeout_flag_clr,
  output logic [7:0] o_data_rdata,
  output logic o_transfer_done_flag,
  output logic o_addr_match_flag,
  output logic o_bus_busy_flag,
  output logic o_slave_rw_flag,
  output logic o_ack_received_flag,
  output logic o_timeout_enable,
  output logic o_timeout_flag,
  output logic [5:0] o_timeout_period_sel,
  output logic o_irq,
  output logic o_wake
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic ovf_m;
    logic ovf_s;
    logic ovf_d;
    i2c_slave_pkg::slave_state_t state;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic tx;
    logic transfer_done_flag;
    logic addr_match_flag;
    logic bus_busy_flag;
    logic slave_rw_flag;
    logic ack_received_flag;
    logic tmo_en;
    logic tmo_flag;
    logic [5:0] tmo_sel;
    logic tmo_armed;
    logic run;
    logic fall_tgl;
    logic sda_oe;
    logic scl_oe;
    logic sda_o;
    logic scl_o;
    logic irq;
    logic wake;
  } core_state_t;

  core_state_t r_reg;
  core_state_t r_next;
  logic active;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic tmo_evt;

  tmo_link_if link ();

  tmo_counter u_tmo_counter (
    .i_sub_clk(i_sub_clk),
    .i_rst(i_rst),
    .link(link.counter)
  );

  // Status flags except the time-out enable and flag back to power-on values; line drivers released and the slave idled.
  function automatic core_state_t flags_por(input core_state_t s);
    core_state_t t;
    t = s;
    t.transfer_done_flag = i2c_slave_pkg::HCF_POR;
    t.addr_match_flag = i2c_slave_pkg::ADDR_MATCH_FLAG_POR;
    t.bus_busy_flag = i2c_slave_pkg::HBB_POR;
    t.slave_rw_flag = i2c_slave_pkg::SRW_POR;
    t.ack_received_flag = i2c_slave_pkg::ACK_RECEIVED_FLAG_POR;
    t.state = i2c_slave_pkg::ST_IDLE;
    t.sda_oe = 1'b0;
    t.scl_oe = 1'b0;
    t.tmo_armed = 1'b0;
    return t;
  endfunction

  // Only the second and third stages of each synchroniser feed the edge and condition detectors.
  assign active = (i_module_mode_sel == i2c_slave_pkg::MODE_I2C_SLAVE) && i_module_enable;
  assign scl_rise = r_reg.scl_s && !r_reg.scl_d;
  assign scl_fall = !r_reg.scl_s && r_reg.scl_d;
  assign start_evt = r_reg.scl_s && r_reg.scl_d && r_reg.sda_d && !r_reg.sda_s;
  assign stop_evt = r_reg.scl_s && r_reg.scl_d && !r_reg.sda_d && r_reg.sda_s;
  assign tmo_evt = (r_reg.ovf_s ^ r_reg.ovf_d) && r_reg.tmo_armed && r_reg.tmo_en;

  always_comb begin
    r_next = r_reg;
    r_next.scl_m = i_scl;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_d = r_reg.scl_s;
    r_next.sda_m = i_sda;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_d = r_reg.sda_s;
    r_next.ovf_m = link.ovf_tgl;
    r_next.ovf_s = r_reg.ovf_m;
    r_next.ovf_d = r_reg.ovf_s;
    r_next.irq = 1'b0;
    r_next.wake = 1'b0;
    r_next.sda_o = 1'b0;
    r_next.scl_o = 1'b0;
    if (i_timeout_wr) begin
      r_next.tmo_en = i_timeout_enable_wdata;
      r_next.tmo_sel = i_timeout_period_wdata;
    end
    if (i_timeout_flag_clr) begin
      r_next.tmo_flag = 1'b0;
    end
    if (scl_fall) begin
      r_next.fall_tgl = ~r_reg.fall_tgl;
    end
    if (!active) begin
      r_next = flags_por(r_next);
    end else if (tmo_evt) begin
      // The hardware event overrides a same-cycle software write or clear.
      r_next = flags_por(r_next);
      r_next.tmo_flag = 1'b1;
      r_next.tmo_en = 1'b0;
      r_next.irq = 1'b1;
    end else if (start_evt) begin
      r_next.bus_busy_flag = 1'b1;
      r_next.transfer_done_flag = 1'b0;
      r_next.state = i2c_slave_pkg::ST_ADDR;
      r_next.cnt = '0;
      r_next.sda_oe = 1'b0;
      r_next.scl_oe = 1'b0;
    end else if (stop_evt) begin
      r_next.bus_busy_flag = 1'b0;
      r_next.state = i2c_slave_pkg::ST_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.scl_oe = 1'b0;
      r_next.tmo_armed = 1'b0;
    end else begin
      case (r_reg.state)
        i2c_slave_pkg::ST_IDLE: begin
          r_next.sda_oe = 1'b0;
        end
        i2c_slave_pkg::ST_ADDR: begin
          if (scl_rise) begin
            r_next.shift = {r_reg.shift[6:0], r_reg.sda_s};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (scl_fall && r_reg.cnt == i2c_slave_pkg::BYTE_BITS) begin
            r_next.transfer_done_flag = 1'b1;
            if (r_reg.shift[7:1] == i_own_address) begin
              r_next.addr_match_flag = 1'b1;
              r_next.slave_rw_flag = r_reg.shift[0];
              r_next.irq = 1'b1;
              r_next.wake = i_match_wake_enable;
              r_next.sda_oe = 1'b1;
              r_next.tmo_armed = 1'b1;
              r_next.state = i2c_slave_pkg::ST_ADDR_ACK;
            end else begin
              r_next.state = i2c_slave_pkg::ST_WAIT_STOP;
            end
          end
        end
        i2c_slave_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            r_next.scl_oe = 1'b1;
            r_next.state = i2c_slave_pkg::ST_HOLD;
          end
        end
        i2c_slave_pkg::ST_HOLD: begin
          // SCL is held low here, so driving SDA cannot look like a START.
          if (i_data_wr) begin
            r_next.shift = i_data_wdata;
          end
          if ((i_transmit_select && i_data_wr) || (!i_transmit_select && i_data_rd)) begin
            r_next.scl_oe = 1'b0;
            r_next.tx = i_transmit_select;
            r_next.sda_oe = i_transmit_select && !i_data_wdata[7];
            r_next.cnt = '0;
            r_next.transfer_done_flag = 1'b0;
            r_next.addr_match_flag = 1'b0;
            r_next.state = i2c_slave_pkg::ST_DATA;
          end
        end
        i2c_slave_pkg::ST_DATA: begin
          if (scl_rise) begin
            r_next.cnt = r_reg.cnt + 4'h1;
            if (!r_reg.tx) begin
              r_next.shift = {r_reg.shift[6:0], r_reg.sda_s};
            end
          end else if (scl_fall) begin
            if (r_reg.cnt == i2c_slave_pkg::BYTE_BITS) begin
              r_next.sda_oe = r_reg.tx ? 1'b0 : !i_ack_to_send;
              r_next.transfer_done_flag = 1'b1;
              r_next.irq = 1'b1;
              r_next.state = i2c_slave_pkg::ST_DATA_ACK;
            end else if (r_reg.tx && r_reg.cnt != 4'h0) begin
              r_next.shift = {r_reg.shift[6:0], 1'b0};
              r_next.sda_oe = !r_reg.shift[6];
            end
          end
        end
        i2c_slave_pkg::ST_DATA_ACK: begin
          if (scl_rise && r_reg.tx) begin
            r_next.ack_received_flag = r_reg.sda_s;
          end else if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            if (r_reg.tx && r_reg.ack_received_flag) begin
              r_next.state = i2c_slave_pkg::ST_WAIT_STOP;
            end else begin
              r_next.scl_oe = 1'b1;
              r_next.state = i2c_slave_pkg::ST_HOLD;
            end
          end
        end
        i2c_slave_pkg::ST_WAIT_STOP: begin
          r_next.sda_oe = 1'b0;
          r_next.scl_oe = 1'b0;
        end
        default: begin
          r_next.state = i2c_slave_pkg::ST_IDLE;
          r_next.sda_oe = 1'b0;
          r_next.scl_oe = 1'b0;
        end
      endcase
    end
    r_next.run = r_next.tmo_armed && r_next.tmo_en;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
      r_reg.scl_m <= 1'b1;
      r_reg.scl_s <= 1'b1;
      r_reg.scl_d <= 1'b1;
      r_reg.sda_m <= 1'b1;
      r_reg.sda_s <= 1'b1;
      r_reg.sda_d <= 1'b1;
      r_reg.state <= i2c_slave_pkg::ST_IDLE;
      r_reg.transfer_done_flag <= i2c_slave_pkg::HCF_POR;
      r_reg.ack_received_flag <= i2c_slave_pkg::ACK_RECEIVED_FLAG_POR;
      r_reg.tmo_en <= i2c_slave_pkg::TMO_EN_POR;
      r_reg.tmo_flag <= i2c_slave_pkg::TMO_FLAG_POR;
      r_reg.tmo_sel <= i2c_slave_pkg::TMO_SEL_POR;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.run = r_reg.run;
  assign link.fall_tgl = r_reg.fall_tgl;
  assign link.period_sel = r_reg.tmo_sel;

  assign o_scl_o = r_reg.scl_o;
  assign o_scl_oe = r_reg.scl_oe;
  assign o_sda_o = r_reg.sda_o;
  assign o_sda_oe = r_reg.sda_oe;
  assign o_data_rdata = r_reg.shift;
  assign o_transfer_done_flag = r_reg.transfer_done_flag;
  assign o_addr_match_flag = r_reg.addr_match_flag;
  assign o_bus_busy_flag = r_reg.bus_busy_flag;
  assign o_slave_rw_flag = r_reg.slave_rw_flag;
  assign o_ack_received_flag = r_reg.ack_received_flag;
  assign o_timeout_enable = r_reg.tmo_en;
  assign o_timeout_flag = r_reg.tmo_flag;
  assign o_timeout_period_sel = r_reg.tmo_sel;
  assign o_irq = r_reg.irq;
  assign o_wake = r_reg.wake;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_start_sets_busy: assert property (active && !tmo_evt && start_evt |=> o_bus_busy_flag)
    else $error("START did not set the busy flag");
  a_stop_clears_busy: assert property (active && !tmo_evt && !start_evt && stop_evt |=> !o_bus_busy_flag)
    else $error("STOP did not clear the busy flag");
  a_match_ack_irq: assert property ($rose(o_addr_match_flag) |-> o_irq && o_sda_oe && r_reg.slave_rw_flag == $past(r_reg.shift[0]))
    else $error("address match without interrupt, ack or read/write capture");
  a_match_wake: assert property ($rose(o_addr_match_flag) |-> o_wake == $past(i_match_wake_enable))
    else $error("wake output does not follow the wake enable on match");
  a_hold_scl_low: assert property (r_reg.state == i2c_slave_pkg::ST_HOLD && active && !tmo_evt && !start_evt && !stop_evt
    && !i_data_wr && !i_data_rd |=> o_scl_oe)
    else $error("SCL released without a data access");
  a_rx_ack_level: assert property (active && !tmo_evt && !start_evt && !stop_evt && r_reg.state == i2c_slave_pkg::ST_DATA
    && !r_reg.tx && scl_fall && r_reg.cnt == i2c_slave_pkg::BYTE_BITS |=> o_sda_oe == !$past(i_ack_to_send) && o_irq)
    else $error("receiver ack level wrong on ninth clock");
  a_done_irq: assert property ($rose(o_transfer_done_flag) && !$past(start_evt) |-> o_irq || !o_addr_match_flag)
    else $error("byte completion without interrupt");
  a_timeout_effect: assert property (active && tmo_evt |=> o_timeout_flag && !o_timeout_enable && o_irq
    && !o_addr_match_flag && !o_bus_busy_flag && o_transfer_done_flag && o_ack_received_flag)
    else $error("time-out did not set flag and restore status");
  a_mode_gate: assert property (!active |=> r_reg.state == i2c_slave_pkg::ST_IDLE && !o_sda_oe && !o_scl_oe)
    else $error("slave active outside I2C slave mode");
  a_no_start_drive: assert property ($rose(o_sda_oe) |-> !r_reg.scl_s)
    else $error("SDA pulled low while SCL high");
  a_open_drain: assert property (!o_sda_o && !o_scl_o)
    else $error("a line was driven high");
  a_nack_release: assert property (r_reg.state == i2c_slave_pkg::ST_WAIT_STOP |-> !o_sda_oe && !o_scl_oe)
    else $error("line held after missing acknowledge");

  c_addr_match: cover property ($rose(o_addr_match_flag));
  c_tx_byte: cover property (r_reg.tx && $rose(o_transfer_done_flag));
  c_rx_byte: cover property (!r_reg.tx && $rose(o_transfer_done_flag));
  c_timeout: cover property (tmo_evt && active);

endmodule

// *** i2c_master_model.sv ***
// Behavioural I2C bus master that drives both wires open-drain.
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int T = 500
) (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end

  // The wait is bounded so that a slave stuck stretching cannot hang the run.
  task automatic rise_scl;
    o_scl_oe = 1'b0;
    for (int k = 0; k < 4000 && i_scl !== 1'b1; k++) #20;
  endtask

  task automatic start;
    o_sda_oe = 1'b1;
    #T o_scl_oe = 1'b1;
  endtask

  task automatic stop;
    #100 o_sda_oe = 1'b1;
    #T rise_scl();
    #T o_sda_oe = 1'b0;
    #T;
  endtask

  task automatic bit_x(input logic b, output logic r);
    #100 o_sda_oe = !b;
    #T rise_scl();
    #T r = i_sda;
    #T o_scl_oe = 1'b1;
  endtask

  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, ak);
  endtask
endmodule

// *** i2c_slave_with_timeout_tb_top.sv ***
// Self-checking testbench for the I2C slave with bus time-out.
`timescale 1ns/1ps
module i2c_slave_with_timeout_tb_top;
  typedef struct {
    logic [6:0] own;
    logic [6:0] addr;
    logic rw;
    logic [7:0] data;
    logic wen;
  } row_t;
  row_t rows [6] = '{'{7'h5A, 7'h5A, 1'b0, 8'hA5, 1'b1}, '{7'h5A, 7'h5A, 1'b1, 8'h3C, 1'b0},
    '{7'h7F, 7'h7F, 1'b1, 8'h80, 1'b1}, '{7'h00, 7'h00, 1'b0, 8'h01, 1'b0},
    '{7'h5A, 7'h5B, 1'b0, 8'h00, 1'b1}, '{7'h5A, 7'h1A, 1'b1, 8'h00, 1'b0}};
  logic clk = 1'b0;
  logic sub_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] mode = 3'h6;
  logic en = 1'b1;
  logic [6:0] own = 7'h00;
  logic tx_sel = 1'b0;
  logic ack_ts = 1'b0;
  logic wake_en = 1'b0;
  logic d_wr = 1'b0;
  logic d_rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic t_wr = 1'b0;
  logic t_en = 1'b0;
  logic [5:0] t_sel = 6'h00;
  logic t_clr = 1'b0;
  logic scl, sda, m_scl_oe, m_sda_oe, scl_o, scl_oe, sda_o, sda_oe;
  logic [7:0] rdata, q;
  logic done, match, busy, slave_rw_flag, ackr, t_en_o, t_flag, irq, wake, ak, hit;
  logic [5:0] t_sel_o;
  int errors = 0;
  int n_compared = 0;
  int irq_cnt = 0;
  int wake_cnt = 0;
  int cyc = 0;
  int ic, wc;

  // Pull-ups on both wires; anyone enabled pulls low.
  assign scl = !(m_scl_oe | (scl_oe & !scl_o));
  assign sda = !(m_sda_oe | (sda_oe & !sda_o));

  i2c_slave_with_timeout i2c_slave_with_timeout_inst (.i_core_clk(clk), .i_rst(rst), .i_sub_clk(sub_clk),
    .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_module_mode_sel(mode), .i_module_enable(en), .i_own_address(own), .i_transmit_select(tx_sel),
    .i_ack_to_send(ack_ts), .i_match_wake_enable(wake_en), .i_data_wr(d_wr), .i_data_wdata(wdata),
    .i_data_rd(d_rd), .i_timeout_wr(t_wr), .i_timeout_enable_wdata(t_en), .i_timeout_period_wdata(t_sel),
    .i_timeout_flag_clr(t_clr), .o_data_rdata(rdata), .o_transfer_done_flag(done),
    .o_addr_match_flag(match), .o_bus_busy_flag(busy), .o_slave_rw_flag(slave_rw_flag), .o_ack_received_flag(ackr),
    .o_timeout_enable(t_en_o), .o_timeout_flag(t_flag), .o_timeout_period_sel(t_sel_o), .o_irq(irq),
    .o_wake(wake));

  i2c_master_model i2c_master_model_inst (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));

  initial begin
    forever #10 clk = !clk;
  end

  initial begin
    #7;
    forever #24 sub_clk = !sub_clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic gap;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic mx(input logic [7:0] d, input logic a);
    i2c_master_model_inst.xfer(d, a, q, ak);
    gap();
  endtask

  // Software access to the data register once the slave is stretching.
  task automatic sw(input logic wr, input logic [7:0] d);
    for (int k = 0; k < 200 && scl_oe !== 1'b1; k++) @(posedge clk);
    check(scl_oe, 1'b1);
    d_wr <= wr;
    d_rd <= !wr;
    wdata <= d;
    @(posedge clk);
    d_wr <= 1'b0;
    d_rd <= 1'b0;
    @(posedge clk);
    #1;
    check(scl_oe, 1'b0);
  endtask

  task automatic por_check;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    gap();
    check({done, ackr, match, busy, slave_rw_flag, t_flag, sda_oe, scl_oe}, 8'hC0);
    check({scl_o, sda_o}, 8'h00);
  endtask

  initial begin
    por_check();
    for (int r = 0; r < 6; r++) begin
      own <= rows[r].own;
      tx_sel <= rows[r].rw;
      wake_en <= rows[r].wen;
      hit = (rows[r].own == rows[r].addr);
      @(posedge clk);
      ic = irq_cnt;
      wc = wake_cnt;
      i2c_master_model_inst.start();
      gap();
      check(busy, 1'b1);
      mx({rows[r].addr, rows[r].rw}, 1'b1);
      check(ak, !hit);
      check(match, hit);
      check(8'(irq_cnt - ic), {7'h00, hit});
      check(8'(wake_cnt - wc), {7'h00, hit & rows[r].wen});
      if (hit) begin
        check(slave_rw_flag, rows[r].rw);
        sw(rows[r].rw, rows[r].data);
        mx(rows[r].rw ? 8'hFF : rows[r].data, 1'b1);
        check(done, 1'b1);
        check(8'(irq_cnt - ic), 8'h02);
        if (rows[r].rw) begin
          check(q, rows[r].data);
          check(ackr, 1'b1);
          check({sda_oe, scl_oe}, 8'h00);
        end else begin
          check(rdata, rows[r].data);
          check(ak, 1'b0);
          sw(1'b0, 8'h00);
        end
      end
      i2c_master_model_inst.stop();
      gap();
      check(busy, 1'b0);
    end
    // Transmit two bytes: acknowledged, then refused.
    own <= 7'h33;
    tx_sel <= 1'b1;
    i2c_master_model_inst.start();
    mx({7'h33, 1'b1}, 1'b1);
    sw(1'b1, 8'hC3);
    mx(8'hFF, 1'b0);
    check(q, 8'hC3);
    check(ackr, 1'b0);
    sw(1'b1, 8'h5E);
    mx(8'hFF, 1'b1);
    check(q, 8'h5E);
    check(ackr, 1'b1);
    i2c_master_model_inst.stop();
    // Receiver answers with a negative acknowledge when told to.
    tx_sel <= 1'b0;
    ack_ts <= 1'b1;
    i2c_master_model_inst.start();
    mx({7'h33, 1'b0}, 1'b1);
    sw(1'b0, 8'h00);
    mx(8'h96, 1'b1);
    check(ak, 1'b1);
    sw(1'b0, 8'h00);
    i2c_master_model_inst.stop();
    ack_ts <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      mode <= (c == 0) ? 3'h5 : 3'h6;
      en <= (c == 0);
      i2c_master_model_inst.start();
      mx({7'h33, 1'b0}, 1'b1);
      check({ak, match, busy}, 8'h04);
      i2c_master_model_inst.stop();
    end
    mode <= 3'h6;
    en <= 1'b1;
    t_en <= 1'b1;
    t_sel <= 6'h01;
    t_wr <= 1'b1;
    @(posedge clk);
    t_wr <= 1'b0;
    gap();
    check({t_en_o, t_sel_o}, 8'h41);
    i2c_master_model_inst.start();
    mx({7'h33, 1'b0}, 1'b1);
    ic = irq_cnt;
    // Bus now stalls; two period units of 32 subclocks are about 154 core cycles.
    repeat (120) @(posedge clk);
    check(t_flag, 1'b0);
    for (int k = 0; k < 60 && t_flag !== 1'b1; k++) @(posedge clk);
    gap();
    check({t_flag, t_en_o}, 8'h02);
    check(8'(irq_cnt - ic), 8'h01);
    check({done, ackr, match, busy, slave_rw_flag, sda_oe, scl_oe}, 8'h60);
    t_clr <= 1'b1;
    @(posedge clk);
    t_clr <= 1'b0;
    gap();
    check(t_flag, 1'b0);
    i2c_master_model_inst.stop();
    por_check();
    wrap_up();
  end
endmodule
